// >>> hw/tag_cmd_pkg.sv
// constants for the tag command interpreter and log formatter
package tag_cmd_pkg;
	// command codes
	localparam logic [7:0] CMD_INVENTORY = 8'h01;
	localparam logic [7:0] CMD_SET_LOG_MODE = 8'ha1;
	localparam logic [7:0] CMD_SET_LIMITS = 8'ha2;
	localparam logic [7:0] CMD_START_LOG = 8'ha7;
	localparam logic [7:0] CMD_GET_LOG_STATE = 8'ha8;
	localparam logic [7:0] CMD_GET_BATTERY = 8'haa;
	localparam logic [7:0] CMD_INITIALIZE = 8'hac;
	localparam logic [7:0] CMD_GET_TEMP = 8'had;
	// error codes
	localparam logic [7:0] ERR_NO_CMD = 8'h01;
	localparam logic [7:0] ERR_FORMAT = 8'h02;
	localparam logic [7:0] ERR_OPTION = 8'h03;
	localparam logic [7:0] ERR_UNKNOWN = 8'h0f;
	localparam logic [7:0] ERR_BLK_NA = 8'h10;
	localparam logic [7:0] ERR_BLK_RELOCK = 8'h11;
	localparam logic [7:0] ERR_BLK_LOCKED = 8'h12;
	localparam logic [7:0] ERR_PASSWORD = 8'ha0;
	localparam logic [7:0] ERR_NO_PARAMS = 8'ha1;
	localparam logic [7:0] ERR_BATT = 8'ha2;
	localparam logic [7:0] ERR_TEMP = 8'ha3;
	localparam logic [7:0] ERR_USER_AREA = 8'ha5;
	localparam logic [7:0] ERR_COLLISION = 8'ha6;
	// request flag bit positions
	localparam int FL_SUBCARRIER = 0;
	localparam int FL_DATARATE = 1;
	localparam int FL_INVENTORY = 2;
	localparam int FL_PROT_EXT = 3;
	localparam int FL_SELECT = 4;
	localparam int FL_ADDRESS = 5;
	localparam int FL_SLOTS = 5;
	localparam int FL_AFI = 4;
	localparam int FL_OPTION = 6;
	localparam int FL_RESERVED_FUTURE = 7;
	// response flag bit positions
	localparam int RFL_ERROR = 0;
	// log mode word fields
	localparam int LM_FORM_HI = 30;
	localparam int LM_FORM_LO = 29;
	localparam int LM_BATT_CHK = 0;
	localparam logic [1:0] FORM_DENSE = 2'b00;
	localparam logic [1:0] FORM_OUT_LIMITS = 2'b01;
	localparam logic [1:0] FORM_ILLEGAL = 2'b10;
	localparam logic [1:0] FORM_CROSSING = 2'b11;
	// limits word fields: low limit 9..0, high limit 25..16
	localparam int LIM_LO_LSB = 0;
	localparam int LIM_HI_LSB = 16;
	// initialize parameter: delay 11..0, user blocks 23..16
	localparam int INIT_DELAY_LSB = 0;
	localparam int INIT_BLOCKS_LSB = 16;
	// register offsets
	localparam logic [7:0] REG_LOG_MODE = 8'h00;
	localparam logic [7:0] REG_LIMITS = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_OOL_COUNT = 8'h0c;
	localparam logic [7:0] REG_INIT = 8'h10;
	// reset values
	localparam logic [31:0] LOG_MODE_RST = 32'h0000_0000;
	localparam logic [31:0] LIMITS_RST = 32'h03ff_0000;
	// response payload lengths in bytes
	localparam logic [3:0] LEN_NONE = 4'h0;
	localparam logic [3:0] LEN_BYTE = 4'h1;
	localparam logic [3:0] LEN_TEMP = 4'h2;
	localparam logic [3:0] LEN_STATE = 4'h8;
	typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_LOG} phase_t;
endpackage

// >>> hw/err_code_filter.sv
// passes codes 10, 11, 12, a0, a5, a6 and 0f, maps anything else to unknown
`timescale 1ns/1ps
module err_code_filter
	import tag_cmd_pkg::*;
(
	input  wire logic [7:0] code_in,
	output logic      [7:0] code_out
);
	wire known = (code_in == ERR_BLK_NA) || (code_in == ERR_BLK_RELOCK) ||
		(code_in == ERR_BLK_LOCKED) || (code_in == ERR_PASSWORD) ||
		(code_in == ERR_USER_AREA) || (code_in == ERR_COLLISION) ||
		(code_in == ERR_UNKNOWN);
	assign code_out = known ? code_in : ERR_UNKNOWN; // (R11) (R12) (R13)
endmodule

// >>> hw/log_word_packer.sv
// builds the log word for the active logging form
`timescale 1ns/1ps
module log_word_packer
	import tag_cmd_pkg::*;
(
	input  wire logic [1:0]  form,
	input  wire logic        batt_chk,
	input  wire logic [9:0]  temp1,
	input  wire logic [9:0]  temp2,
	input  wire logic [9:0]  temp3,
	input  wire logic [9:0]  batt,
	input  wire logic [11:0] index,
	output logic      [31:0] word
);
	wire [31:0] dense_word = {2'b00, temp3, temp2, temp1}; // (R15)
	wire [9:0]  batt_field = batt_chk ? batt : 10'h000; // (R21)
	wire [31:0] limit_word = {index, batt_field, temp3}; // (R20)
	assign word = (form == FORM_DENSE) ? dense_word : limit_word; // (R14)
endmodule

// >>> hw/tag_cmd_logger.sv
// command interpreter and data log formatter of the sensor tag
// How it works
// (R01) battery command answers flags and level
// (R02) initialize takes delay and block count
// (R03) temperature command answers flags and 16 bits
// (R04) inventory flags decoded apart from others
// (R05) b0 subcarrier, b1 data rate
// (R06) inventory: b2 set, no AFI, b5 slots
// (R07) others: b4 select, b5 addressed
// (R08) reader keeps b3, b6, b7 clear
// (R09) one error reply: flags, code, crc
// (R10) codes 01, 02, 03, 0f for command faults
// (R11) codes 10, 11, 12 for block faults
// (R12) a0 password, a1 missing log parameters
// (R13) a2, a3, a5, a6 measurement and memory faults
// (R14) logging form sits in log mode bits 30:29
// (R15) dense form packs three temperatures per word
// (R16) dense word written after third measurement
// (R17) form 01 logs out-of-limit measurements only
// (R18) form 11 logs limit crossings only
// (R19) form 10 refused as unsupported option
// (R20) limit word: index 31:20, temperature 9:0
// (R21) battery in 19:10 when check set
// (R22) out-of-limits counter kept in limit forms
// (R23) set log mode stores 32-bit word
// (R24) log state answers status then counter
// (R25) delay counts only after start log
// (R26) error reply sets response error flag
`timescale 1ns/1ps
module tag_cmd_logger
	import tag_cmd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        req_valid,
	input  wire logic [7:0]  req_flags,
	input  wire logic [7:0]  req_cmd,
	input  wire logic [31:0] req_param,
	input  wire logic        req_format_bad,
	input  wire logic        req_uid_match,
	input  wire logic        tag_selected,
	input  wire logic [7:0]  ext_err,
	input  wire logic        ee_busy,
	input  wire logic        meas_valid,
	input  wire logic [9:0]  meas_temp,
	input  wire logic [9:0]  meas_batt,
	input  wire logic        temp_fault,
	input  wire logic        batt_fault,
	input  wire logic        delay_tick,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             rsp_valid,
	output logic      [7:0]  rsp_flags,
	output logic      [3:0]  rsp_len,
	output logic      [63:0] rsp_data,
	output logic             rsp_double_sub,
	output logic             rsp_high_rate,
	output logic             inv_req,
	output logic             inv_one_slot,
	output logic             log_wr,
	output logic      [11:0] log_block,
	output logic      [31:0] log_word,
	output logic             logging
);
	logic [31:0] log_mode;
	logic [31:0] limits;
	logic [11:0] delay_val;
	logic [7:0]  user_blocks;
	logic [11:0] delay_cnt;
	logic        params_set;
	phase_t      phase;
	logic [11:0] meas_index;
	logic [31:0] ool_count;
	logic [1:0]  dense_cnt;
	logic [9:0]  dense_t1;
	logic [9:0]  dense_t2;
	logic        was_outside;
	logic [9:0]  last_temp;
	logic [9:0]  last_batt;
	logic [7:0]  ext_code;
	logic [31:0] packed_word;

	// request decode
	wire is_inv = req_cmd == CMD_INVENTORY;
	wire reserved_set = req_flags[FL_PROT_EXT] | req_flags[FL_OPTION] |
		req_flags[FL_RESERVED_FUTURE]; // (R08)
	wire inv_bad = ~req_flags[FL_INVENTORY] | req_flags[FL_AFI]; // (R06)
	wire other_bad = req_flags[FL_INVENTORY]; // (R07)
	wire not_for_us = ~is_inv & ((req_flags[FL_ADDRESS] & ~req_uid_match) |
		(req_flags[FL_SELECT] & ~tag_selected)); // (R07)
	wire cmd_known = (req_cmd == CMD_SET_LOG_MODE) || (req_cmd == CMD_SET_LIMITS) ||
		(req_cmd == CMD_START_LOG) || (req_cmd == CMD_GET_LOG_STATE) ||
		(req_cmd == CMD_GET_BATTERY) || (req_cmd == CMD_INITIALIZE) ||
		(req_cmd == CMD_GET_TEMP);
	wire cmd_writes = (req_cmd == CMD_SET_LOG_MODE) || (req_cmd == CMD_SET_LIMITS) ||
		(req_cmd == CMD_START_LOG) || (req_cmd == CMD_INITIALIZE);
	wire [1:0] req_form = req_param[LM_FORM_HI:LM_FORM_LO];

	// error selection, first match wins
	logic [7:0] err_code;
	always_comb begin
		err_code = 8'h00;
		if (req_format_bad)
			err_code = ERR_FORMAT; // (R10)
		else if (reserved_set | (is_inv ? inv_bad : other_bad))
			err_code = ERR_OPTION; // (R10)
		else if (!cmd_known && !is_inv)
			err_code = ERR_NO_CMD; // (R10)
		else if (ext_err != 8'h00)
			err_code = ext_code; // (R11)
		else if (req_cmd == CMD_SET_LOG_MODE && req_form == FORM_ILLEGAL)
			err_code = ERR_OPTION; // (R19)
		else if (cmd_writes && ee_busy)
			err_code = ERR_COLLISION; // (R13)
		else if (req_cmd == CMD_START_LOG && !params_set)
			err_code = ERR_NO_PARAMS; // (R12)
		else if (req_cmd == CMD_GET_BATTERY && batt_fault)
			err_code = ERR_BATT; // (R13)
		else if (req_cmd == CMD_GET_TEMP && temp_fault)
			err_code = ERR_TEMP; // (R13)
	end

	err_code_filter u_filter (
		.code_in  (ext_err),
		.code_out (ext_code)
	);

	wire has_err = err_code != 8'h00;
	wire take = req_valid & ~not_for_us & (~is_inv | has_err);
	wire accept = take & ~has_err;
	wire do_mode = accept & (req_cmd == CMD_SET_LOG_MODE);
	wire do_limits = accept & (req_cmd == CMD_SET_LIMITS);
	wire do_init = accept & (req_cmd == CMD_INITIALIZE);
	wire do_start = accept & (req_cmd == CMD_START_LOG);

	// register bus decode
	wire wr_mode = reg_wr & (reg_addr == REG_LOG_MODE);
	wire wr_limits = reg_wr & (reg_addr == REG_LIMITS);
	wire [31:0] status_word = {4'h0, meas_index, 13'h0000, params_set,
		phase == PH_DELAY, phase == PH_LOG};
	logic [31:0] next_rdata;
	always_comb begin
		case (reg_addr)
			REG_LOG_MODE:  next_rdata = log_mode;
			REG_LIMITS:    next_rdata = limits;
			REG_STATUS:    next_rdata = status_word;
			REG_OOL_COUNT: next_rdata = ool_count;
			REG_INIT:      next_rdata = {8'h00, user_blocks, 4'h0, delay_val};
			default:       next_rdata = 32'h0000_0000;
		endcase
	end

	// response payload
	logic [63:0] next_data;
	logic [3:0]  next_len;
	always_comb begin
		next_data = 64'h0;
		next_len = LEN_NONE;
		if (has_err) begin
			next_data = {err_code, 56'h0}; // (R09)
			next_len = LEN_BYTE;
		end else begin
			case (req_cmd)
				CMD_GET_BATTERY: begin
					next_data = {last_batt[9:2], 56'h0}; // (R01)
					next_len = LEN_BYTE;
				end
				CMD_GET_TEMP: begin
					next_data = {6'h00, last_temp, 48'h0}; // (R03)
					next_len = LEN_TEMP;
				end
				CMD_GET_LOG_STATE: begin
					next_data = {status_word, ool_count}; // (R24)
					next_len = LEN_STATE;
				end
				default: begin
					next_data = 64'h0; // (R02)
					next_len = LEN_NONE;
				end
			endcase
		end
	end

	// measurement handling
	wire [1:0] form = log_mode[LM_FORM_HI:LM_FORM_LO]; // (R14)
	wire [9:0] lim_lo = limits[LIM_LO_LSB +: 10];
	wire [9:0] lim_hi = limits[LIM_HI_LSB +: 10];
	wire outside = (meas_temp < lim_lo) | (meas_temp > lim_hi);
	wire limit_form = (form == FORM_OUT_LIMITS) | (form == FORM_CROSSING);
	wire take_meas = meas_valid & (phase == PH_LOG);
	wire dense_full = dense_cnt == 2'd2;
	logic next_log;
	always_comb begin
		case (form)
			FORM_DENSE:      next_log = dense_full; // (R16)
			FORM_OUT_LIMITS: next_log = outside; // (R17)
			FORM_CROSSING:   next_log = outside != was_outside; // (R18)
			default:         next_log = 1'b0;
		endcase
	end

	log_word_packer u_packer (
		.form     (form),
		.batt_chk (log_mode[LM_BATT_CHK]),
		.temp1    (dense_t1),
		.temp2    (dense_t2),
		.temp3    (meas_temp),
		.batt     (meas_batt),
		.index    (meas_index),
		.word     (packed_word)
	);

	// response outputs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_flags <= 8'h00;
			rsp_len <= LEN_NONE;
			rsp_data <= 64'h0;
			rsp_double_sub <= 1'b0;
			rsp_high_rate <= 1'b0;
			inv_req <= 1'b0;
			inv_one_slot <= 1'b0;
		end else begin
			rsp_valid <= take;
			inv_req <= req_valid & is_inv & ~has_err; // (R04)
			if (req_valid) begin
				rsp_flags <= {7'h00, has_err}; // (R26)
				rsp_len <= next_len;
				rsp_data <= next_data;
				rsp_double_sub <= req_flags[FL_SUBCARRIER]; // (R05)
				rsp_high_rate <= req_flags[FL_DATARATE]; // (R05)
				inv_one_slot <= is_inv & req_flags[FL_SLOTS]; // (R06)
			end
		end
	end

	// configuration, written by commands or the register port
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			log_mode <= LOG_MODE_RST;
			limits <= LIMITS_RST;
			params_set <= 1'b0;
			delay_val <= 12'h000;
			user_blocks <= 8'h00;
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
			if (do_mode) begin
				log_mode <= req_param; // (R23)
				params_set <= 1'b1;
			end else if (wr_mode && reg_wdata[LM_FORM_HI:LM_FORM_LO] != FORM_ILLEGAL) begin
				log_mode <= reg_wdata; // (R19)
				params_set <= 1'b1;
			end
			if (do_limits)
				limits <= req_param;
			else if (wr_limits)
				limits <= reg_wdata;
			if (do_init) begin
				delay_val <= req_param[INIT_DELAY_LSB +: 12]; // (R02)
				user_blocks <= req_param[INIT_BLOCKS_LSB +: 8]; // (R02)
			end
		end
	end

	// logging phase and delay countdown
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			phase <= PH_IDLE;
			delay_cnt <= 12'h000;
		end else begin
			case (phase)
				PH_IDLE: begin
					if (do_start) begin
						delay_cnt <= delay_val; // (R25)
						phase <= (delay_val == 12'h000) ? PH_LOG : PH_DELAY;
					end
				end
				PH_DELAY: begin
					if (delay_tick) begin
						delay_cnt <= delay_cnt - 12'h001; // (R25)
						if (delay_cnt == 12'h001)
							phase <= PH_LOG;
					end
				end
				PH_LOG: begin
					if (do_init || do_mode)
						phase <= PH_IDLE;
				end
				default: phase <= PH_IDLE;
			endcase
		end
	end

	// measurement capture, log writes and limit counter
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meas_index <= 12'h000;
			ool_count <= 32'h0000_0000;
			dense_cnt <= 2'd0;
			dense_t1 <= 10'h000;
			dense_t2 <= 10'h000;
			was_outside <= 1'b0;
			last_temp <= 10'h000;
			last_batt <= 10'h000;
			log_wr <= 1'b0;
			log_block <= 12'h000;
			log_word <= 32'h0000_0000;
			logging <= 1'b0;
		end else begin
			logging <= phase == PH_LOG;
			log_wr <= take_meas & next_log;
			if (meas_valid) begin
				last_temp <= meas_temp;
				last_batt <= meas_batt;
			end
			if (do_start) begin
				meas_index <= 12'h000;
				ool_count <= 32'h0000_0000;
				dense_cnt <= 2'd0;
				was_outside <= 1'b0;
				log_block <= 12'h000;
			end else if (take_meas) begin
				meas_index <= meas_index + 12'h001;
				was_outside <= outside;
				if (limit_form && outside)
					ool_count <= ool_count + 32'h0000_0001; // (R22)
				if (form == FORM_DENSE) begin
					dense_cnt <= dense_full ? 2'd0 : dense_cnt + 2'd1; // (R15)
					if (dense_cnt == 2'd0)
						dense_t1 <= meas_temp;
					if (dense_cnt == 2'd1)
						dense_t2 <= meas_temp;
				end
				if (next_log) begin
					log_word <= packed_word; // (R20)
					log_block <= log_block + 12'h001;
				end
			end
		end
	end
endmodule

// >>> verif/tag_cmd_logger_chk.sv
// port assertions for the tag command logger
`timescale 1ns/1ps
module tag_cmd_logger_chk
	import tag_cmd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        req_valid,
	input  wire logic [7:0]  req_flags,
	input  wire logic [7:0]  req_cmd,
	input  wire logic        req_format_bad,
	input  wire logic [7:0]  ext_err,
	input  wire logic        temp_fault,
	input  wire logic        meas_valid,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        rsp_valid,
	input  wire logic [7:0]  rsp_flags,
	input  wire logic [3:0]  rsp_len,
	input  wire logic [63:0] rsp_data,
	input  wire logic        rsp_double_sub,
	input  wire logic        rsp_high_rate,
	input  wire logic        inv_req,
	input  wire logic        inv_one_slot,
	input  wire logic        log_wr,
	input  wire logic        logging
);
	wire clean = req_valid && req_flags == 8'h00 && !req_format_bad && ext_err == 8'h00;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	fmt_err_a: assert property (req_valid && req_format_bad && req_flags[5:4] == 2'b00
		|=> rsp_valid && rsp_flags == 8'h01 && rsp_data[63:56] == ERR_FORMAT)
		else $error("format reply wrong");
	err_flag_a: assert property (
		rsp_valid && rsp_flags[RFL_ERROR] |-> rsp_len == LEN_BYTE)
		else $error("error reply length wrong");
	mode_bits_a: assert property (rsp_valid |-> $past(req_valid)
		&& rsp_double_sub == $past(req_flags[0]) && rsp_high_rate == $past(req_flags[1]))
		else $error("reply mode bits wrong");
	inv_pass_a: assert property (req_valid && req_cmd == CMD_INVENTORY
		&& (req_flags & 8'hdc) == 8'h04 && !req_format_bad && ext_err == 8'h00
		|=> inv_req && !rsp_valid && inv_one_slot == $past(req_flags[5]))
		else $error("inventory not passed on");
	rsv_bits_a: assert property (req_valid && !req_format_bad && req_flags[5:4] == 2'b00
		&& (req_flags & 8'hc8) != 8'h00 |=> rsp_valid && rsp_data[63:56] == ERR_OPTION)
		else $error("reserved flag not refused");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	log_cause_a: assert property (log_wr |-> $past(meas_valid) && logging)
		else $error("log write without measurement");
	temp_len_a: assert property (clean && req_cmd == CMD_GET_TEMP && !temp_fault
		|=> rsp_valid && rsp_len == LEN_TEMP && rsp_data[63:58] == 6'h00)
		else $error("temperature reply wrong");
	state_len_a: assert property (clean && req_cmd == CMD_GET_LOG_STATE
		|=> rsp_valid && rsp_flags == 8'h00 && rsp_len == LEN_STATE)
		else $error("log state reply wrong");
endmodule
bind tag_cmd_logger tag_cmd_logger_chk i_chk (.mclk, .nrst, .req_valid, .req_flags, .req_cmd,
	.req_format_bad, .ext_err, .temp_fault, .meas_valid, .reg_rd, .reg_rdata, .rsp_valid,
	.rsp_flags, .rsp_len, .rsp_data, .rsp_double_sub, .rsp_high_rate, .inv_req, .inv_one_slot,
	.log_wr, .logging);

// >>> verif/reader_model.sv
// reader side model: frames one request per call
`timescale 1ns/1ps
module reader_model
	import tag_cmd_pkg::*;
(
	input  wire logic        mclk,
	output logic             req_valid,
	output logic      [7:0]  req_flags,
	output logic      [7:0]  req_cmd,
	output logic      [31:0] req_param,
	output logic             req_format_bad
);
	initial begin
		req_valid = 1'b0;
		req_flags = 8'h00;
		req_cmd = 8'h00;
		req_param = 32'h0;
		req_format_bad = 1'b0;
	end
	// fields scrambled once the frame is gone
	task automatic send(input logic [7:0] f, input logic [7:0] c, input logic [31:0] p,
		input logic bad);
		@(posedge mclk);
		req_valid <= 1'b1;
		req_flags <= f;
		req_cmd <= c;
		req_param <= p;
		req_format_bad <= bad;
		@(posedge mclk);
		req_valid <= 1'b0;
		req_flags <= ~f;
		req_cmd <= ~c;
		req_param <= ~p;
		req_format_bad <= ~bad;
	endtask
	// inventory flags: b2 set, b4 and reserved bits clear
	function automatic logic [7:0] inv_flags(input logic one_slot);
		return {2'b00, one_slot, 5'b00100};
	endfunction
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the tag command logger
`timescale 1ns/1ps
module tb_top
	import tag_cmd_pkg::*;
;
	logic        mclk, nrst, req_valid, req_format_bad, req_uid_match, tag_selected, ee_busy;
	logic        meas_valid, temp_fault, batt_fault, delay_tick, reg_wr, reg_rd, rsp_valid;
	logic        rsp_double_sub, rsp_high_rate, inv_req, inv_one_slot, log_wr, logging;
	logic [7:0]  req_flags, req_cmd, ext_err, reg_addr, rsp_flags;
	logic [31:0] req_param, reg_wdata, reg_rdata, log_word;
	logic [9:0]  meas_temp, meas_batt;
	logic [3:0]  rsp_len;
	logic [63:0] rsp_data;
	logic [11:0] log_block;
	logic [7:0]  codes [7] = '{ERR_UNKNOWN, ERR_BLK_NA, ERR_BLK_RELOCK, ERR_BLK_LOCKED,
		ERR_PASSWORD, ERR_USER_AREA, ERR_COLLISION};
	int          n_fail, comparisons, cycles;
	tag_cmd_logger i_tag_cmd_logger (.mclk, .nrst, .req_valid, .req_flags, .req_cmd, .req_param,
		.req_format_bad, .req_uid_match, .tag_selected, .ext_err, .ee_busy, .meas_valid,
		.meas_temp, .meas_batt, .temp_fault, .batt_fault, .delay_tick, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .rsp_valid, .rsp_flags, .rsp_len, .rsp_data,
		.rsp_double_sub, .rsp_high_rate, .inv_req, .inv_one_slot, .log_wr, .log_block,
		.log_word, .logging);
	reader_model i_reader_model (.mclk, .req_valid, .req_flags, .req_cmd, .req_param,
		.req_format_bad);
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk("reg", reg_rdata, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic req(input logic [7:0] f, input logic [7:0] c, input logic [31:0] p,
		input logic [7:0] ef, input logic [3:0] el, input logic [63:0] m, input logic [63:0] ed);
		i_reader_model.send(f, c, p, 1'b0);
		#1 chk("valid", rsp_valid, 1);
		chk("flags", rsp_flags, ef);
		chk("len", rsp_len, el);
		chk("data", rsp_data & m, ed);
	endtask
	task automatic err(input logic [7:0] f, input logic [7:0] c, input logic [31:0] p,
		input logic [7:0] code);
		req(f, c, p, 8'h01, LEN_BYTE, {8'hff, 56'h0}, {code, 56'h0});
	endtask
	task automatic ok(input logic [7:0] c, input logic [31:0] p);
		req(8'h00, c, p, 8'h00, LEN_NONE, 64'h0, 64'h0);
	endtask
	task automatic meas(input logic [9:0] t, input logic w, input logic [31:0] word);
		@(posedge mclk);
		meas_valid <= 1'b1;
		meas_temp <= t;
		@(posedge mclk);
		meas_valid <= 1'b0;
		#1 chk("log_wr", log_wr, w);
		if (w)
			chk("log_word", log_word, word);
	endtask
	task automatic tick;
		@(posedge mclk);
		delay_tick <= 1'b1;
		@(posedge mclk);
		delay_tick <= 1'b0;
	endtask
	task automatic arm(input logic [31:0] mode);
		ok(CMD_SET_LOG_MODE, mode);
		ok(CMD_START_LOG, 32'h0);
		repeat (2) @(posedge mclk);
	endtask
	initial begin
		{nrst, req_uid_match, tag_selected, ee_busy, meas_valid, temp_fault} = 6'b011000;
		{batt_fault, delay_tick, reg_wr, reg_rd} = 4'h0;
		{ext_err, reg_addr, reg_wdata, meas_temp} = '0;
		meas_batt = 10'h2ad;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		rd(REG_LOG_MODE, LOG_MODE_RST);
		rd(REG_LIMITS, LIMITS_RST);
		wr(REG_LOG_MODE, 32'h4000_0000);
		rd(REG_LOG_MODE, LOG_MODE_RST);
		rd(8'h20, 32'h0);
		$display("test registers done");
		meas(10'h177, 1'b0, 32'h0);
		req(8'h03, CMD_GET_BATTERY, 0, 8'h00, LEN_BYTE, {8'hff, 56'h0}, {8'hab, 56'h0});
		chk("sub", rsp_double_sub, 1);
		chk("rate", rsp_high_rate, 1);
		req(8'h00, CMD_GET_TEMP, 0, 8'h00, LEN_TEMP, {16'hffff, 48'h0}, {16'h0177, 48'h0});
		batt_fault <= 1'b1;
		err(8'h00, CMD_GET_BATTERY, 0, ERR_BATT);
		batt_fault <= 1'b0;
		temp_fault <= 1'b1;
		err(8'h00, CMD_GET_TEMP, 0, ERR_TEMP);
		temp_fault <= 1'b0;
		$display("test readings done");
		err(8'h00, 8'h55, 0, ERR_NO_CMD);
		i_reader_model.send(8'h00, CMD_GET_TEMP, 0, 1'b1);
		#1 chk("format", rsp_data[63:56], ERR_FORMAT);
		err(8'h08, CMD_GET_TEMP, 0, ERR_OPTION);
		err(8'h04, CMD_GET_TEMP, 0, ERR_OPTION);
		err(8'h14, CMD_INVENTORY, 0, ERR_OPTION);
		err(8'h00, CMD_START_LOG, 0, ERR_NO_PARAMS);
		err(8'h00, CMD_SET_LOG_MODE, 32'h4000_0000, ERR_OPTION);
		ee_busy <= 1'b1;
		err(8'h00, CMD_INITIALIZE, 0, ERR_COLLISION);
		ee_busy <= 1'b0;
		foreach (codes[i]) begin
			ext_err <= codes[i];
			err(8'h00, CMD_GET_LOG_STATE, 0, codes[i]);
		end
		ext_err <= 8'h77;
		err(8'h00, CMD_GET_LOG_STATE, 0, ERR_UNKNOWN);
		ext_err <= 8'h00;
		$display("test errors done");
		i_reader_model.send(i_reader_model.inv_flags(1'b1), CMD_INVENTORY, 0, 1'b0);
		#1 chk("inv", inv_req, 1);
		chk("slot", inv_one_slot, 1);
		req_uid_match <= 1'b0;
		i_reader_model.send(8'h20, CMD_GET_TEMP, 0, 1'b0);
		#1 chk("quiet", rsp_valid, 0);
		req_uid_match <= 1'b1;
		$display("test flags done");
		ok(CMD_INITIALIZE, 32'h0005_0002);
		rd(REG_INIT, 32'h0005_0002);
		ok(CMD_SET_LOG_MODE, 32'h2000_0001);
		ok(CMD_SET_LIMITS, 32'h00c8_0064);
		ok(CMD_START_LOG, 32'h0);
		tick();
		#1 chk("logging", logging, 0);
		tick();
		repeat (2) @(posedge mclk);
		#1 chk("logging", logging, 1);
		meas(10'd50, 1'b1, {12'd0, 10'h2ad, 10'd50});
		meas(10'd150, 1'b0, 32'h0);
		meas(10'd300, 1'b1, {12'd2, 10'h2ad, 10'd300});
		chk("log_block", log_block, 2);
		req(8'h00, CMD_GET_LOG_STATE, 0, 8'h00, LEN_STATE, 64'hffff_ffff, 64'd2);
		rd(REG_OOL_COUNT, 32'd2);
		rd(REG_STATUS, 32'h0003_0005);
		$display("test out of limits done");
		ok(CMD_INITIALIZE, 32'h0);
		arm(32'h6000_0000);
		meas(10'd150, 1'b0, 32'h0);
		meas(10'd50, 1'b1, {12'd1, 10'h0, 10'd50});
		meas(10'd60, 1'b0, 32'h0);
		meas(10'd150, 1'b1, {12'd3, 10'h0, 10'd150});
		chk("log_block", log_block, 2);
		$display("test crossing done");
		arm(32'h0);
		meas(10'd1, 1'b0, 32'h0);
		meas(10'd2, 1'b0, 32'h0);
		meas(10'd3, 1'b1, {2'b00, 10'd3, 10'd2, 10'd1});
		chk("log_block", log_block, 1);
		$display("test dense done");
		tally_and_finish();
	end
endmodule
